// ===== rtl/sas_adc_map.vh
// register map and timing constants for the converter sequencer
`ifndef SAS_ADC_MAP_VH
`define SAS_ADC_MAP_VH

// register indices; byte address is four times the index
`define SAS_IDX_CTL 6'h30
`define SAS_IDX_RES1 6'h31
`define SAS_IDX_RES2 6'h32
`define SAS_IDX_RES3 6'h33
`define SAS_IDX_RES4 6'h34
`define SAS_IDX_OPT 6'h39
`define SAS_IDX_W 6

// control/status field positions
`define SAS_CTL_CCF 7
`define SAS_CTL_SCAN 5
`define SAS_CTL_MULTI_CHANNEL_SELECT 4
`define SAS_CTL_CH_HI 3
`define SAS_CTL_CH_LO 0

// options field positions
`define SAS_OPT_PU 7
`define SAS_OPT_CONVERTER_CLOCK_SELECT 6

// reset values
`define SAS_CTL_RST 6'h00
`define SAS_RES_RST 8'h00

// conversion timing in converter ticks
`define SAS_SAMPLE_TICKS 5'h0C
`define SAS_STEP_TICKS 5'h04
`define SAS_BITS 3'h7

// ahb encodings
`define SAS_HTRANS_NONSEQ 2'h2
`define SAS_HSIZE_WORD 3'h2

`endif

// ===== rtl/sas_adc_seq.v
// successive-approximation converter sequencer with ahb-lite registers
//
// Notes on behaviour
// - four-bit field picks one of sixteen inputs
// - eight port pins feed multiplexer, plus internals
// - eight comparisons per conversion, MSB first
// - finished approximation copied into its slot
// - four readable eight-bit result registers
// - result update never collides with a read
// - sequences of four, once or repeating
// - complete flag set after fourth conversion
// - sequence starts one cycle after control write
// - low reference 00, high FF, no overflow
// - input switch closed only in 12-tick sample
// - power-up bit 7 enables converter, pump
// - clock select: bus clock or RC oscillator
// - bus clock mode is fully synchronous
// - control write aborts, restarts, clears flag if no sequence ends that cycle
// - repeat bit: once then halt, or forever
// - multi bit: one channel or four-group
// - flag bit 7 read-only, bit 6 zero
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sas_adc_map.vh"

module sas_adc_seq (
    input wire clk_i,
    input wire rst_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // analog side
    input wire comp_i,
    input wire rc_clk_i,
    output reg [3:0] channel_sel_o,
    output reg [7:0] port_pin_gate_o,
    output reg internal_gate_o,
    output reg sample_switch_o,
    output reg [7:0] dac_code_o,
    output reg converter_power_up_o,
    output reg charge_pump_en_o,
    output reg converter_clock_select_o
);

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SAMPLE = 2'h1;
    localparam [1:0] ST_COMPARE = 2'h2;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg ctl_scan_ff;
    reg ctl_multi_channel_select_ff;
    reg [3:0] ctl_ch_ff;
    reg ccf_ff;
    reg opt_pu_ff;
    reg opt_converter_clock_select_ff;
    reg [7:0] res_ff [0:3];
    reg wr_pend_ff;
    reg [`SAS_IDX_W-1:0] wr_idx_ff;
    reg start_ff;
    reg [1:0] state_ff;
    reg [4:0] tick_cnt_ff;
    reg [2:0] bit_ff;
    reg [1:0] slot_ff;
    reg [7:0] sar_ff;
    reg comp_s1_ff;
    reg comp_s2_ff;
    reg rc_s1_ff;
    reg rc_s2_ff;
    reg rc_s3_ff;
    reg [1:0] nxt_state;
    reg [4:0] nxt_tick_cnt;
    reg [2:0] nxt_bit;
    reg [1:0] nxt_slot;
    reg [7:0] nxt_sar;
    reg res_we;
    reg seq_done;
    reg [31:0] nxt_rdata;
    reg [3:0] cur_ch;
    wire addr_phase;
    wire [`SAS_IDX_W-1:0] addr_idx;
    wire ctl_wr;
    wire opt_wr;
    wire conv_tick;
    wire powered;
    integer i;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // a valid word transfer in its address phase
    assign addr_phase = hsel_i && hready_i &&
                        (htrans_i == `SAS_HTRANS_NONSEQ) &&
                        (hsize_i == `SAS_HSIZE_WORD);
    assign addr_idx = haddr_i[`SAS_IDX_W+1:2];
    // writes land in the data phase, together with hwdata
    assign ctl_wr = wr_pend_ff && (wr_idx_ff == `SAS_IDX_CTL);
    assign opt_wr = wr_pend_ff && (wr_idx_ff == `SAS_IDX_OPT);

    // read data prepared in the address phase, zero wait states
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (addr_idx)
            `SAS_IDX_CTL: begin
                // flag read-only, bit 6 always zero
                nxt_rdata[7:0] = {ccf_ff, 1'b0, ctl_scan_ff, ctl_multi_channel_select_ff,
                                  ctl_ch_ff};
            end
            `SAS_IDX_RES1: begin
                nxt_rdata[7:0] = res_ff[0];
            end
            `SAS_IDX_RES2: begin
                nxt_rdata[7:0] = res_ff[1];
            end
            `SAS_IDX_RES3: begin
                nxt_rdata[7:0] = res_ff[2];
            end
            `SAS_IDX_RES4: begin
                nxt_rdata[7:0] = res_ff[3];
            end
            `SAS_IDX_OPT: begin
                nxt_rdata[`SAS_OPT_PU] = opt_pu_ff;
                nxt_rdata[`SAS_OPT_CONVERTER_CLOCK_SELECT] = opt_converter_clock_select_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // bus pipeline registers and response
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= {`SAS_IDX_W{1'b0}};
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend_ff <= addr_phase && hwrite_i;
            wr_idx_ff <= addr_idx;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (addr_phase && !hwrite_i) begin
                hrdata_o <= nxt_rdata;
            end
        end
    end

    // control and option registers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_scan_ff <= 1'b0;
            ctl_multi_channel_select_ff <= 1'b0;
            ctl_ch_ff <= 4'h0;
            opt_pu_ff <= 1'b0;
            opt_converter_clock_select_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            start_ff <= ctl_wr; // start follows the write by one cycle
            if (ctl_wr) begin
                ctl_scan_ff <= hwdata_i[`SAS_CTL_SCAN];
                ctl_multi_channel_select_ff <= hwdata_i[`SAS_CTL_MULTI_CHANNEL_SELECT];
                ctl_ch_ff <= hwdata_i[`SAS_CTL_CH_HI:`SAS_CTL_CH_LO];
            end
            if (opt_wr) begin
                opt_pu_ff <= hwdata_i[`SAS_OPT_PU];
                opt_converter_clock_select_ff <= hwdata_i[`SAS_OPT_CONVERTER_CLOCK_SELECT];
            end
        end
    end

    // ------------------------------------------------------------
    // converter timing source
    // ------------------------------------------------------------
    // comparator and oscillator are asynchronous: two-stage sync
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
            rc_s1_ff <= 1'b0;
            rc_s2_ff <= 1'b0;
            rc_s3_ff <= 1'b0;
        end else begin
            comp_s1_ff <= comp_i;
            comp_s2_ff <= comp_s1_ff;
            rc_s1_ff <= rc_clk_i;
            rc_s2_ff <= rc_s1_ff;
            rc_s3_ff <= rc_s2_ff;
        end
    end

    // bus clock ticks every cycle, oscillator ticks on its rise
    assign conv_tick = opt_converter_clock_select_ff ? (rc_s2_ff && !rc_s3_ff) : 1'b1;
    assign powered = opt_pu_ff;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    // channel of the current slot: group of four when multi is set
    always @* begin
        if (ctl_multi_channel_select_ff) begin
            cur_ch = {ctl_ch_ff[3:2], slot_ff};
        end else begin
            cur_ch = ctl_ch_ff;
        end
    end

    // next-state logic
    always @* begin
        nxt_state = state_ff;
        nxt_tick_cnt = tick_cnt_ff;
        nxt_bit = bit_ff;
        nxt_slot = slot_ff;
        nxt_sar = sar_ff;
        res_we = 1'b0;
        seq_done = 1'b0;
        if (start_ff) begin
            // any control write aborts and restarts at slot one
            nxt_state = powered ? ST_SAMPLE : ST_IDLE;
            nxt_tick_cnt = 5'h00;
            nxt_bit = `SAS_BITS;
            nxt_slot = 2'h0;
            nxt_sar = 8'h00;
        end else if (!powered) begin
            nxt_state = ST_IDLE; // unpowered converter halts
        end else if (conv_tick) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_SAMPLE: begin
                    // fixed sample window
                    if (tick_cnt_ff == `SAS_SAMPLE_TICKS - 5'h01) begin
                        nxt_state = ST_COMPARE;
                        nxt_tick_cnt = 5'h00;
                        nxt_bit = `SAS_BITS;
                        nxt_sar = 8'h80; // trial msb first
                    end else begin
                        nxt_tick_cnt = tick_cnt_ff + 5'h01;
                    end
                end
                ST_COMPARE: begin
                    if (tick_cnt_ff == `SAS_STEP_TICKS - 5'h01) begin
                        nxt_tick_cnt = 5'h00;
                        // comparator high: trial above input, drop bit
                        if (comp_s2_ff) begin
                            nxt_sar[bit_ff] = 1'b0;
                        end
                        if (bit_ff == 3'h0) begin
                            res_we = 1'b1;
                            nxt_slot = slot_ff + 2'h1;
                            if (slot_ff == 2'h3) begin
                                seq_done = 1'b1;
                                // halt or repeat
                                nxt_state = ctl_scan_ff ? ST_SAMPLE : ST_IDLE;
                            end else begin
                                nxt_state = ST_SAMPLE;
                            end
                        end else begin
                            nxt_bit = bit_ff - 3'h1;
                            nxt_sar[bit_ff - 3'h1] = 1'b1; // next trial bit
                        end
                    end else begin
                        nxt_tick_cnt = tick_cnt_ff + 5'h01;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // sequencer registers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            tick_cnt_ff <= 5'h00;
            bit_ff <= `SAS_BITS;
            slot_ff <= 2'h0;
            sar_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            tick_cnt_ff <= nxt_tick_cnt;
            bit_ff <= nxt_bit;
            slot_ff <= nxt_slot;
            sar_ff <= nxt_sar;
        end
    end

    // result slots; read data is latched from the old value on the
    // same edge, so update and read never conflict
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                res_ff[i] <= `SAS_RES_RST;
            end
        end else if (res_we) begin
            // raw code: no overflow indication
            res_ff[slot_ff] <= nxt_sar;
        end
    end

    // completion flag: set after fourth slot, cleared by control write; a set in the same cycle wins
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ccf_ff <= 1'b0;
        end else if (seq_done) begin
            ccf_ff <= 1'b1;
        end else if (ctl_wr) begin
            ccf_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // analog drive
    // ------------------------------------------------------------
    // registered outputs to the multiplexer, switch and dac
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            channel_sel_o <= 4'h0;
            port_pin_gate_o <= 8'h00;
            internal_gate_o <= 1'b0;
            sample_switch_o <= 1'b0;
            dac_code_o <= 8'h00;
            converter_power_up_o <= 1'b0;
            charge_pump_en_o <= 1'b0;
            converter_clock_select_o <= 1'b0;
        end else begin
            channel_sel_o <= cur_ch;
            // switch closed only in the sample window
            sample_switch_o <= (nxt_state == ST_SAMPLE);
            // port pins are channels 0-7, others internal
            port_pin_gate_o <= 8'h00;
            if ((nxt_state == ST_SAMPLE) && !cur_ch[3]) begin
                port_pin_gate_o[cur_ch[2:0]] <= 1'b1;
            end
            internal_gate_o <= (nxt_state == ST_SAMPLE) && cur_ch[3];
            dac_code_o <= nxt_sar;
            converter_power_up_o <= opt_pu_ff;
            charge_pump_en_o <= opt_pu_ff;
            converter_clock_select_o <= opt_converter_clock_select_ff;
        end
    end

endmodule // sas_adc_seq
`default_nettype wire

// ===== tb/sas_ana_model.sv
// comparator and sample-and-hold model of the analog side
`timescale 1ns/10ps
`default_nettype none
module sas_ana_model (
    input wire logic clk_i,
    input wire logic [7:0] base_i,
    input wire logic [3:0] channel_sel_i,
    input wire logic sample_switch_i,
    input wire logic [7:0] dac_code_i,
    output logic comp_o
);
    logic [7:0] held_ff = 8'h00;
    // port pins are never read digitally while sampling
    // the array keeps what the shut switch passed in
    always @(posedge clk_i) begin
        if (sample_switch_i) begin
            held_ff <= base_i ^ {channel_sel_i, channel_sel_i};
        end
    end
    // a trial above the held level drops the bit
    assign comp_o = dac_code_i > held_ff;
endmodule // sas_ana_model
`default_nettype wire

// ===== tb/sas_adc_seq_monitor.sv
// assertion checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_adc_seq_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [3:0] channel_sel_o,
    input wire [7:0] port_pin_gate_o,
    input wire internal_gate_o,
    input wire sample_switch_o,
    input wire [7:0] dac_code_o,
    input wire converter_power_up_o,
    input wire charge_pump_en_o,
    input wire converter_clock_select_o
);
    // ----
    // helpers
    // ----
    wire ctl_wr = hsel_i && hreadyout_o && htrans_i == 2'h2 && hwrite_i
        && hsize_i == 3'h2 && haddr_i[7:2] == 6'h30;
    wire bus_run = converter_power_up_o && !converter_clock_select_o;
    logic [4:0] since_wr_ff;
    logic [4:0] run_ff;
    // age of the last control write and length of the window
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_wr_ff <= 5'h00;
            run_ff <= 5'h00;
        end else begin
            since_wr_ff <= ctl_wr ? 5'h00
                : since_wr_ff + {4'h0, ~&since_wr_ff};
            run_ff <= sample_switch_o ? run_ff + 5'h01 : 5'h00;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // power must still stand when the write lands in its data phase
    sequence s_start;
        ctl_wr && bus_run ##1 converter_power_up_o;
    endsequence
    sequence s_open;
        ##[1:2] sample_switch_o;
    endsequence
    AST_START: assert property (s_start |-> s_open)
        else $error("no sample window after control write");
    AST_SAMPLE_LEN: assert property ($fell(sample_switch_o)
        && bus_run && since_wr_ff == 5'h1F |-> run_ff == 5'h0C)
        else $error("sample window length off");
    AST_MSB: assert property ($fell(sample_switch_o) && bus_run
        && since_wr_ff > 5'h04 |-> ##[0:1] dac_code_o == 8'h80)
        else $error("first trial is not the top bit");
    AST_BUS: assert property (hreadyout_o && !hresp_o)
        else $error("bus stalled or errored");
    AST_PIN_GATE: assert property (sample_switch_o
        && !channel_sel_o[3]
        |-> port_pin_gate_o == 8'h01 << channel_sel_o[2:0]
        && !internal_gate_o)
        else $error("wrong pin gate");
    AST_INT_GATE: assert property (sample_switch_o
        && channel_sel_o[3] |-> internal_gate_o && port_pin_gate_o == 8'h00)
        else $error("wrong internal gate");
    AST_GATE_OFF: assert property (!sample_switch_o
        |-> port_pin_gate_o == 8'h00 && !internal_gate_o)
        else $error("gate open outside window");
    AST_PUMP: assert property (charge_pump_en_o
        == converter_power_up_o)
        else $error("pump differs from power");
    AST_OFF: assert property (!converter_power_up_o
        && $past(converter_power_up_o) == 1'b0 |-> !sample_switch_o)
        else $error("sampling while unpowered");
endmodule // sas_adc_seq_monitor

bind sas_adc_seq sas_adc_seq_monitor u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .channel_sel_o(channel_sel_o),
    .port_pin_gate_o(port_pin_gate_o),
    .internal_gate_o(internal_gate_o),
    .sample_switch_o(sample_switch_o),
    .dac_code_o(dac_code_o),
    .converter_power_up_o(converter_power_up_o),
    .charge_pump_en_o(charge_pump_en_o),
    .converter_clock_select_o(converter_clock_select_o)
);
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rc_clk_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [7:0] base = 8'h00;
    logic rd_dp = 1'b0;
    wire [31:0] hrdata_o;
    wire hreadyout_o;
    wire comp;
    wire sw;
    wire [3:0] ch_sel;
    wire [7:0] dac;
    int n_mismatch = 0;
    int checked = 0;
    logic [31:0] expq[$];
    // bus clock and a free-running oscillator of unrelated phase
    always #2.5 clk_i = ~clk_i;
    always #18.5 rc_clk_i = ~rc_clk_i;
    sas_adc_seq DUT (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(), .comp_i(comp),
        .rc_clk_i(rc_clk_i), .channel_sel_o(ch_sel), .port_pin_gate_o(),
        .internal_gate_o(), .sample_switch_o(sw), .dac_code_o(dac),
        .converter_power_up_o(), .charge_pump_en_o(),
        .converter_clock_select_o()
    );
    sas_ana_model u_ana (
        .clk_i(clk_i), .base_i(base), .channel_sel_i(ch_sel),
        .sample_switch_i(sw), .dac_code_i(dac), .comp_o(comp)
    );
    // ----
    // tasks
    // ----
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: read %h, want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one single word transfer; a read notes its expected word
    task xfer(input logic w, input logic [5:0] i, input logic [31:0] d);
        if (!w) expq.push_back(d);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, i, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        hsize_i <= 3'h2;
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= w ? d : $urandom;
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
    endtask
    // start a sequence, let it finish, read flag and four slots
    task run_seq(input logic [7:0] b, input logic [5:0] c, input int n);
        logic [3:0] ch;
        base <= b;
        xfer(1'b1, 6'h30, {24'h0, 2'b11, c});
        xfer(1'b0, 6'h30, {24'h0, 2'b00, c});
        repeat (n) @(posedge clk_i);
        xfer(1'b0, 6'h30, {24'h0, 2'b10, c});
        for (int k = 0; k < 4; k++) begin
            ch = c[4] ? {c[3:2], 2'(k)} : c[3:0];
            xfer(1'b0, 6'h31 + 6'(k), {24'h0, b ^ {ch, ch}});
        end
    endtask
    // compare each read data phase with the oldest note
    always @(posedge clk_i) begin
        if (rd_dp && hreadyout_o) chk(hrdata_o, expq.pop_front());
        if (hreadyout_o) rd_dp <= hsel_i && htrans_i == 2'h2 && !hwrite_i;
    end
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        void'($urandom(32'h291BD74E));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b0, 6'h30, 32'h0);
        xfer(1'b0, 6'h34, 32'h0);
        xfer(1'b1, 6'h3F, 32'hFF);
        xfer(1'b0, 6'h3F, 32'h0);
        xfer(1'b1, 6'h39, 32'h80); // bus clock is fast enough
        xfer(1'b0, 6'h39, 32'h80);
        repeat (20000) @(posedge clk_i);
        run_seq(8'h00, 6'h00, 184);
        run_seq(8'h00, 6'h1C, 184);
        for (int k = 0; k < 4; k++) begin
            run_seq(8'($urandom), {2'(k), 4'($urandom)}, 184);
        end
        xfer(1'b1, 6'h30, 32'h25);
        repeat (30) @(posedge clk_i);
        run_seq(8'($urandom), 6'h13, 184);
        xfer(1'b1, 6'h39, 32'hC0);
        run_seq(8'h5A, 6'h06, 1500);
        xfer(1'b1, 6'h39, 32'h00);
        xfer(1'b1, 6'h30, 32'h03);
        repeat (184) @(posedge clk_i);
        xfer(1'b0, 6'h30, 32'h03);
        xfer(1'b0, 6'h31, 32'h3C);
        test_done();
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
